// File: ogm_chan_if.sv
interface ogm_chan_if;
  logic [15:0] sample_in;
  logic [12:0] gain;
  logic signed [15:0] offset;
  logic clip_en;
  logic [7:0] clip_level;
  logic bin_fmt;
  logic [15:0] range_limit;
  logic [15:0] sample_out;
  logic clip_over;
  logic range_err;
  logic signed [6:0] top7;
  modport ctl (output sample_in, gain, offset, clip_en, clip_level, bin_fmt, range_limit,
    input sample_out, clip_over, range_err, top7);
  modport chan (input sample_in, gain, offset, clip_en, clip_level, bin_fmt, range_limit,
    output sample_out, clip_over, range_err, top7);
endinterface

// File: ogm_channel.sv
module ogm_channel (
  ogm_chan_if.chan c
);
  // ==========================================
  // format in: binary offset becomes signed by flipping the sign bit
  logic signed [15:0] s_in;
  logic signed [29:0] prod;
  logic signed [16:0] scaled;
  logic signed [16:0] sum;
  logic signed [15:0] sat;
  logic signed [16:0] upper;
  logic signed [16:0] lower;
  logic over_hi;
  logic over_lo;
  logic signed [15:0] clipped;
  logic signed [16:0] thr;
  assign s_in = c.bin_fmt ? {~c.sample_in[15], c.sample_in[14:0]} : c.sample_in;
  assign c.top7 = s_in[15:9];
  // ==========================================
  // gain, then offset, so a muted path still shows the offset
  // offset after gain
  assign prod = s_in * $signed({1'b0, c.gain});
  assign scaled = prod[27:11];
  assign sum = scaled + {c.offset[15], c.offset};
  // saturate instead of wrapping when offset pushes past 16 bits
  assign sat = (sum > 17'sh07fff) ? 16'sh7fff : (sum < -17'sh08000) ? 16'sh8000 : sum[15:0];
  // ==========================================
  // level ff opens the full code range, otherwise 128 per step
  assign upper = (c.clip_level == 8'hff) ? 17'sh07fff : $signed({2'h0, c.clip_level, 7'h00});
  assign lower = (c.clip_level == 8'hff) ? -17'sh08000 : -upper;
  assign over_hi = sat > upper;
  assign over_lo = sat < lower;
  assign clipped = !c.clip_en ? sat : over_hi ? upper[15:0] : over_lo ? lower[15:0] : sat;
  assign c.clip_over = c.clip_en & (over_hi | over_lo);
  assign c.sample_out = c.bin_fmt ? {~clipped[15], clipped[14:0]} : clipped;
  // ==========================================
  // strict window around the center
  assign thr = $signed({1'b0, c.range_limit});
  assign c.range_err = !((s_in > -thr) && (s_in < thr));
endmodule

// File: ogm_defines.svh
`ifndef OGM_DEFINES_SVH
`define OGM_DEFINES_SVH
// ==========================================
// register offsets (word index)
`define OGM_OFF_CTRL 4'h0
`define OGM_OFF_RATES 4'h1
`define OGM_OFF_WAIT 4'h2
`define OGM_OFF_OFS_A 4'h3
`define OGM_OFF_OFS_B 4'h4
`define OGM_OFF_CLIP 4'h5
`define OGM_OFF_PWIN 4'h6
`define OGM_OFF_PTHR 4'h7
`define OGM_OFF_RANGE 4'h8
`define OGM_OFF_EVEN 4'h9
`define OGM_OFF_STATUS 4'ha
`define OGM_OFF_PAVG 4'hb
`define OGM_OFF_GAIN 4'hc
// ==========================================
// control register fields
`define OGM_CTRL_MUTE_ON 0
`define OGM_CTRL_IGN_PIN 1
`define OGM_CTRL_PIN_DIR 2
`define OGM_CTRL_SW_MUTE 3
`define OGM_CTRL_CLIP_EN 4
`define OGM_CTRL_BIN_FMT 5
`define OGM_CTRL_ALM_REL 6
`define OGM_CTRL_RST 7'h01
// ==========================================
// reset values and datapath constants
`define OGM_RATES_RST 16'h3333
`define OGM_WAIT_RST 16'h0000
`define OGM_CLIP_RST 8'hff
`define OGM_PTHR_RST 16'hffff
`define OGM_RANGE_RST 16'hffff
`define OGM_EVEN_RST 6'h00
`define OGM_GAIN_FULL 13'h0800
`define OGM_GAIN_STEP 13'h0080
`define OGM_GAIN_SHIFT 11
`define OGM_TICK_BASE 8
// step counts for the odd ramp codes above 8, which stop doubling
`define OGM_STEP_9 19'haab
`define OGM_STEP_11 19'h1555
`define OGM_STEP_13 19'h2aa3
`define OGM_STEP_15 19'h8000
`define OGM_PWIN_MIN 6
`endif

// File: ogm_output_guard.sv
// Overview of operation
// - Each category's 4-bit ramp code sets step time, eight clocks doubled per code up to code 8.
// - Mute wait lasts programmed wait count plus one, times eight clocks.
// - Direct, data, incident: wait until period ends or the event releases.
// - Alarm mute waits until host writes the alarm release bit.
// - Each channel adds its own signed 16-bit DC offset.
// - Offset is added after gain, so muted output keeps the offset.
// - With clipping on, output is held within 128 times level of mid-scale.
// - Samples past a limit are replaced by that limit.
// - Level 00h pins output to mid-scale; FFh allows the full code range.
// - Either channel beyond the clip level raises the over-range event.
// - Pair power uses only the seven top bits of I and Q.
// - Power averages over 2^6 to 2^21 pairs chosen by window length.
// - Average above the 16-bit threshold sets power flag, may request mute.
// - Range checker tests I and Q strictly inside plus-minus limit around center.
// - A sample outside the range raises the pair range error.
// - Active-low output enable pin is a direct mute request.
// - Reset leaves pin input, pin event honoured, controller enabled.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`include "ogm_defines.svh"
module ogm_output_guard #(
  parameter int WIN_MAX = 15
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // sample stream, I on a, Q on b
  input wire logic [15:0] i_sample_a,
  input wire logic [15:0] i_sample_b,
  input wire logic i_data_invalid,
  output logic [15:0] o_sample_a,
  output logic [15:0] o_sample_b,
  // pin and status
  input wire logic i_output_enable_pin_n,
  output logic o_muted,
  output ogm_pkg::ogm_state_t o_mute_state,
  output logic o_clip_overrange_event,
  output logic o_power_over_flag,
  output logic o_pair_range_error
);
  import ogm_pkg::*;
  // ==========================================
  // configuration registers
  logic [6:0] ctrl_reg;
  logic [15:0] rates_reg, wait_reg, ofs_a_reg, ofs_b_reg, pthr_reg, range_reg;
  logic [7:0] clip_reg;
  logic [3:0] pwin_reg;
  logic [5:0] even_reg;
  logic sel_ctrl, sel_rates, sel_wait, sel_ofs_a, sel_ofs_b, sel_clip;
  logic sel_pwin, sel_pthr, sel_range, sel_even;
  logic alarm_release;
  logic [15:0] rdata_next;
  assign sel_ctrl = i_addr == `OGM_OFF_CTRL;
  assign sel_rates = i_addr == `OGM_OFF_RATES;
  assign sel_wait = i_addr == `OGM_OFF_WAIT;
  assign sel_ofs_a = i_addr == `OGM_OFF_OFS_A;
  assign sel_ofs_b = i_addr == `OGM_OFF_OFS_B;
  assign sel_clip = i_addr == `OGM_OFF_CLIP;
  assign sel_pwin = i_addr == `OGM_OFF_PWIN;
  assign sel_pthr = i_addr == `OGM_OFF_PTHR;
  assign sel_range = i_addr == `OGM_OFF_RANGE;
  assign sel_even = i_addr == `OGM_OFF_EVEN;
  // release bit is a write pulse, never stored
  assign alarm_release = i_wr & sel_ctrl & i_wdata[`OGM_CTRL_ALM_REL];
  // register writes
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      // pin input, event honoured, controller on
      ctrl_reg <= `OGM_CTRL_RST;
      rates_reg <= `OGM_RATES_RST;
      wait_reg <= `OGM_WAIT_RST;
      ofs_a_reg <= 16'h0000;
      ofs_b_reg <= 16'h0000;
      clip_reg <= `OGM_CLIP_RST;
      pwin_reg <= 4'h0;
      pthr_reg <= `OGM_PTHR_RST;
      range_reg <= `OGM_RANGE_RST;
      even_reg <= `OGM_EVEN_RST;
    end else if (i_wr) begin
      if (sel_ctrl) begin
        ctrl_reg <= {1'b0, i_wdata[5:0]};
      end else if (sel_rates) begin
        rates_reg <= i_wdata;
      end else if (sel_wait) begin
        wait_reg <= i_wdata;
      end else if (sel_ofs_a) begin
        ofs_a_reg <= i_wdata;
      end else if (sel_ofs_b) begin
        ofs_b_reg <= i_wdata;
      end else if (sel_clip) begin
        clip_reg <= i_wdata[7:0];
      end else if (sel_pwin) begin
        pwin_reg <= i_wdata[3:0];
      end else if (sel_pthr) begin
        pthr_reg <= i_wdata;
      end else if (sel_range) begin
        range_reg <= i_wdata;
      end else if (sel_even) begin
        even_reg <= i_wdata[5:0];
      end
    end
  end
  // ==========================================
  // channel datapath
  logic [12:0] gain_reg;
  ogm_chan_if ch_a ();
  ogm_chan_if ch_b ();
  assign ch_a.sample_in = i_sample_a;
  assign ch_b.sample_in = i_sample_b;
  assign ch_a.gain = gain_reg;
  assign ch_b.gain = gain_reg;
  assign ch_a.offset = ofs_a_reg;
  assign ch_b.offset = ofs_b_reg;
  assign ch_a.clip_en = ctrl_reg[`OGM_CTRL_CLIP_EN];
  assign ch_b.clip_en = ctrl_reg[`OGM_CTRL_CLIP_EN];
  assign ch_a.clip_level = clip_reg;
  assign ch_b.clip_level = clip_reg;
  assign ch_a.bin_fmt = ctrl_reg[`OGM_CTRL_BIN_FMT];
  assign ch_b.bin_fmt = ctrl_reg[`OGM_CTRL_BIN_FMT];
  assign ch_a.range_limit = range_reg;
  assign ch_b.range_limit = range_reg;
  ogm_channel u_chan_a (.c(ch_a.chan));
  ogm_channel u_chan_b (.c(ch_b.chan));
  // outputs and level flags, refreshed every sample
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_sample_a <= 16'h0000;
      o_sample_b <= 16'h0000;
      o_clip_overrange_event <= 1'b0;
      o_pair_range_error <= 1'b0;
    end else begin
      o_sample_a <= ch_a.sample_out;
      o_sample_b <= ch_b.sample_out;
      o_clip_overrange_event <= ch_a.clip_over | ch_b.clip_over;
      // I or Q out of range
      o_pair_range_error <= ch_a.range_err | ch_b.range_err;
    end
  end
  // ==========================================
  // power meter
  logic [13:0] pair_pow;
  logic [34:0] acc_reg;
  logic [20:0] pair_cnt_reg;
  logic [4:0] win_log2;
  logic win_done;
  logic [34:0] avg_full;
  logic [15:0] pavg_reg;
  assign pair_pow = 14'(ch_a.top7 * ch_a.top7) + 14'(ch_b.top7 * ch_b.top7);
  // window of 2^6 .. 2^21 pairs
  assign win_log2 = 5'(`OGM_PWIN_MIN) + {1'b0, (pwin_reg > 4'(WIN_MAX)) ? 4'(WIN_MAX) : pwin_reg};
  assign win_done = pair_cnt_reg == 21'((22'h1 << win_log2) - 22'h1);
  assign avg_full = (acc_reg + {21'h0, pair_pow}) >> win_log2;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      acc_reg <= 35'h0;
      pair_cnt_reg <= 21'h0;
      pavg_reg <= 16'h0000;
      o_power_over_flag <= 1'b0;
    end else if (win_done) begin
      acc_reg <= 35'h0;
      pair_cnt_reg <= 21'h0;
      pavg_reg <= avg_full[15:0];
      o_power_over_flag <= avg_full[15:0] > pthr_reg;
    end else begin
      acc_reg <= acc_reg + {21'h0, pair_pow};
      pair_cnt_reg <= pair_cnt_reg + 21'h1;
    end
  end
  // ==========================================
  // mute request sources
  logic mute_on, pin_req, direct_req, alarm_req, data_req, incident_req, any_req;
  logic [2:0] det_ev;
  ogm_cat_t req_cat;
  assign mute_on = ctrl_reg[`OGM_CTRL_MUTE_ON];
  // low pin requests a direct mute
  assign pin_req = ~i_output_enable_pin_n & ~ctrl_reg[`OGM_CTRL_PIN_DIR]
    & ~ctrl_reg[`OGM_CTRL_IGN_PIN];
  assign direct_req = pin_req | ctrl_reg[`OGM_CTRL_SW_MUTE];
  assign det_ev = {o_pair_range_error, o_power_over_flag, o_clip_overrange_event};
  assign alarm_req = |(det_ev & even_reg[2:0]);
  assign data_req = i_data_invalid;
  assign incident_req = |(det_ev & even_reg[5:3]);
  assign any_req = direct_req | alarm_req | data_req | incident_req;
  assign req_cat = direct_req ? OGM_DIRECT : alarm_req ? OGM_ALARM :
    data_req ? OGM_DATA : OGM_INCIDENT;
  // ==========================================
  // mute controller
  ogm_state_t state_reg, state_next;
  ogm_cat_t cat_reg;
  logic [3:0] rate_sel;
  logic [18:0] step_cnt_reg, step_len;
  logic [19:0] wait_cnt_reg, wait_len;
  logic step_tick, wait_done, cat_req, alarm_latch_reg;
  assign rate_sel = rates_reg[{cat_reg, 2'b00} +: 4];
  // above code 8 even codes double every second code, odd codes are fixed counts
  assign step_len = (rate_sel <= 4'h8) ? 19'(`OGM_TICK_BASE) << rate_sel :
    (rate_sel == 4'hf) ? `OGM_STEP_15 : (rate_sel == 4'hd) ? `OGM_STEP_13 :
    (rate_sel == 4'hb) ? `OGM_STEP_11 : (rate_sel == 4'h9) ? `OGM_STEP_9 :
    19'(`OGM_TICK_BASE) << (4'(rate_sel[3:1]) + 4'h4);
  assign step_tick = step_cnt_reg == step_len - 19'h1;
  // (count + 1) x 8 clocks
  assign wait_len = ({4'h0, wait_reg} + 20'h1) << 3;
  assign wait_done = wait_cnt_reg == 20'h0;
  assign cat_req = (cat_reg == OGM_DIRECT) ? direct_req : (cat_reg == OGM_DATA) ? data_req :
    incident_req;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      OGM_RUN: begin
        if (any_req) begin
          state_next = OGM_MUTE;
        end
      end
      OGM_MUTE: begin
        if (gain_reg == 13'h0) begin
          state_next = OGM_WAIT;
        end
      end
      OGM_WAIT: begin
        // alarm leaves only on the release write
        if (cat_reg == OGM_ALARM) begin
          if (!alarm_latch_reg) begin
            state_next = OGM_DEMUTE;
          end
        // leave once the period ends or the event drops
        end else if (wait_done || !cat_req) begin
          state_next = OGM_DEMUTE;
        end
      end
      default: begin
        if (any_req) begin
          state_next = OGM_MUTE;
        end else if (gain_reg == `OGM_GAIN_FULL) begin
          state_next = OGM_RUN;
        end
      end
    endcase
  end
  // state, category, ramp timing
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !mute_on) begin
      state_reg <= OGM_RUN;
      cat_reg <= OGM_DIRECT;
      step_cnt_reg <= 19'h0;
      wait_cnt_reg <= 20'h0;
    end else begin
      state_reg <= state_next;
      if (state_next == OGM_MUTE && state_reg != OGM_MUTE) begin
        cat_reg <= req_cat;
      end
      step_cnt_reg <= (step_tick || state_next != state_reg) ? 19'h0 : step_cnt_reg + 19'h1;
      if (state_next == OGM_WAIT && state_reg != OGM_WAIT) begin
        wait_cnt_reg <= wait_len - 20'h1;
      end else if (!wait_done) begin
        wait_cnt_reg <= wait_cnt_reg - 20'h1;
      end
    end
  end
  // gain ramp and alarm hold; a pending event beats a release in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      gain_reg <= `OGM_GAIN_FULL;
      alarm_latch_reg <= 1'b0;
    end else begin
      alarm_latch_reg <= alarm_req | (alarm_latch_reg & ~alarm_release);
      if (!mute_on) begin
        gain_reg <= `OGM_GAIN_FULL;
      end else if (state_reg == OGM_MUTE && step_tick) begin
        gain_reg <= (gain_reg > `OGM_GAIN_STEP) ? gain_reg - `OGM_GAIN_STEP : 13'h0;
      end else if (state_reg == OGM_DEMUTE && step_tick) begin
        gain_reg <= (gain_reg < `OGM_GAIN_FULL - `OGM_GAIN_STEP) ?
          gain_reg + `OGM_GAIN_STEP : `OGM_GAIN_FULL;
      end
    end
  end
  // ==========================================
  // register readback
  always_comb begin
    rdata_next = 16'h0000;
    if (sel_ctrl) begin
      rdata_next = {10'h0, ctrl_reg[5:0]};
    end else if (sel_rates) begin
      rdata_next = rates_reg;
    end else if (sel_wait) begin
      rdata_next = wait_reg;
    end else if (sel_ofs_a) begin
      rdata_next = ofs_a_reg;
    end else if (sel_ofs_b) begin
      rdata_next = ofs_b_reg;
    end else if (sel_clip) begin
      rdata_next = {8'h0, clip_reg};
    end else if (sel_pwin) begin
      rdata_next = {12'h0, pwin_reg};
    end else if (sel_pthr) begin
      rdata_next = pthr_reg;
    end else if (sel_range) begin
      rdata_next = range_reg;
    end else if (sel_even) begin
      rdata_next = {10'h0, even_reg};
    end else if (i_addr == `OGM_OFF_STATUS) begin
      rdata_next = {8'h0, cat_reg, state_reg, alarm_latch_reg, det_ev[2:1],
        det_ev[0]};
    end else if (i_addr == `OGM_OFF_PAVG) begin
      rdata_next = pavg_reg;
    end else if (i_addr == `OGM_OFF_GAIN) begin
      rdata_next = {3'h0, gain_reg};
    end
  end
  // read data only in the cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
      o_muted <= 1'b0;
      o_mute_state <= OGM_RUN;
    end else begin
      o_rdata <= i_rd ? rdata_next : 16'h0000;
      o_muted <= gain_reg == 13'h0;
      o_mute_state <= state_reg;
    end
  end
  // ==========================================
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  sequence enter_wait_s;
    state_reg != OGM_WAIT ##1 state_reg == OGM_WAIT;
  endsequence
  sequence ramp_step_s;
    state_reg == OGM_MUTE && step_tick && gain_reg > `OGM_GAIN_STEP;
  endsequence
  ramp_step_time_a: assert property ((ramp_step_s ##1 state_reg == OGM_MUTE) |->
    step_cnt_reg == 19'h0 ##(1) step_cnt_reg == 19'h1)
    else $error("ramp step counter did not restart");
  wait_load_a: assert property (enter_wait_s |->
    wait_cnt_reg == ($past(wait_len) - 20'h1))
    else $error("wait period loaded wrongly");
  wait_release_a: assert property ((state_reg == OGM_WAIT && cat_reg != OGM_ALARM
    && !wait_done && cat_req && mute_on) |=> state_reg == OGM_WAIT)
    else $error("left wait early");
  alarm_hold_a: assert property ((state_reg == OGM_WAIT && cat_reg == OGM_ALARM
    && alarm_latch_reg && mute_on) |=> state_reg == OGM_WAIT)
    else $error("alarm wait released without release bit");
  muted_offset_a: assert property ((gain_reg == 13'h0 && !ch_a.clip_en
    && !ch_a.bin_fmt) |=> o_sample_a == $past(ofs_a_reg))
    else $error("muted output lost its offset");
  clip_bound_a: assert property ((ch_a.clip_en && clip_reg != 8'hff) |=>
    ($signed(o_sample_a ^ {$past(ch_a.bin_fmt), 15'h0}) <=
    $signed({1'b0, $past(clip_reg), 7'h00})))
    else $error("clipped sample above limit");
  clip_off_a: assert property (!ch_a.clip_en |=> !o_clip_overrange_event)
    else $error("over-range raised with clipping off");
  power_flag_a: assert property (win_done |=>
    o_power_over_flag == (pavg_reg > $past(pthr_reg)))
    else $error("power flag does not match average");
  range_flag_a: assert property ((ch_a.range_err || ch_b.range_err) |=> o_pair_range_error)
    else $error("range error missed");
  pin_mute_a: assert property ((state_reg == OGM_RUN && mute_on && pin_req)
    |=> state_reg == OGM_MUTE ##1 state_reg == OGM_MUTE)
    else $error("pin low did not start a mute");
  reset_cfg_a: assert property ($fell(i_reset) |-> mute_on && !ctrl_reg[1]
    && !ctrl_reg[2])
    else $error("reset configuration wrong");
endmodule

// File: ogm_output_guard_test.sv
`include "ogm_defines.svh"
module ogm_output_guard_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] nxt_i = 16'h0000;
  logic [15:0] nxt_q = 16'h0000;
  logic mute_req = 1'b0;
  logic bad_data = 1'b0;
  logic [15:0] o_rdata, o_sample_a, o_sample_b, s_a, s_b, rd;
  logic data_inv, pin_n, o_muted, o_clip_overrange_event, o_power_over_flag, o_pair_range_error;
  ogm_pkg::ogm_state_t o_mute_state;
  int fails = 0;
  int tests_run = 0;
  int n;
  // ==========================================
  // partner and design
  ogm_stream_source src (.i_sys_clk(i_sys_clk), .i_next_i(nxt_i), .i_next_q(nxt_q),
    .i_mute_req(mute_req), .i_data_bad(bad_data), .o_sample_a(s_a), .o_sample_b(s_b),
    .o_data_invalid(data_inv), .o_output_enable_pin_n(pin_n));
  ogm_output_guard dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sample_a(s_a),
    .i_sample_b(s_b), .i_data_invalid(data_inv), .o_sample_a(o_sample_a),
    .o_sample_b(o_sample_b), .i_output_enable_pin_n(pin_n), .o_muted(o_muted),
    .o_mute_state(o_mute_state), .o_clip_overrange_event(o_clip_overrange_event),
    .o_power_over_flag(o_power_over_flag), .o_pair_range_error(o_pair_range_error));
  initial begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // ==========================================
  // shared helpers
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // register bus: one-cycle strobes, read data only in the next cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    rd = o_rdata;
  endtask
  // pair needs two edges to reach the outputs; a third lets it settle
  task automatic drive(input logic [15:0] a, input logic [15:0] b);
    @(posedge i_sys_clk);
    nxt_i <= a;
    nxt_q <= b;
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic clip_case(input logic [15:0] a, b, ea, eb, input logic ev);
    drive(a, b);
    check(o_sample_a, ea);
    check(o_sample_b, eb);
    check({15'h0000, o_clip_overrange_event}, {15'h0000, ev});
  endtask
  task automatic range_case(input logic [15:0] a, b, input logic ev);
    drive(a, b);
    check({15'h0000, o_pair_range_error}, {15'h0000, ev});
  endtask
  // bounded wait on the mute state, n returns the cycles spent
  task automatic wait_state(input ogm_pkg::ogm_state_t st, input int lim);
    n = 0;
    while (o_mute_state !== st) begin
      @(posedge i_sys_clk);
      #1;
      n++;
      if (n > lim) begin
        fails++;
        $display("BAD t=%0t state=%h exp=%h", $time, o_mute_state, st);
        final_report();
      end
    end
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    #1; // let the release edge settle
    check({15'h0000, o_muted}, 16'h0000);
    rd_reg(`OGM_OFF_CTRL);
    check(rd, 16'h0001);
    rd_reg(`OGM_OFF_RATES);
    check(rd, 16'h3333);
    rd_reg(`OGM_OFF_CLIP);
    check(rd, 16'h00ff);
    rd_reg(`OGM_OFF_RANGE);
    check(rd, 16'hffff);
    wr(4'hf, 16'h1234);
    rd_reg(4'hf);
    check(rd, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_offset();
    wr(`OGM_OFF_OFS_A, 16'h0010);
    wr(`OGM_OFF_OFS_B, 16'h8000);
    clip_case(16'h0100, 16'h0000, 16'h0110, 16'h8000, 1'b0);
    wr(`OGM_OFF_OFS_A, 16'h0001);
    clip_case(16'h7fff, 16'h0000, 16'h7fff, 16'h8000, 1'b0);
    wr(`OGM_OFF_OFS_A, 16'h0000);
    wr(`OGM_OFF_OFS_B, 16'h0000);
    $display("offset test done");
  endtask
  task automatic t_clip();
    wr(`OGM_OFF_CTRL, 16'h0031);
    wr(`OGM_OFF_CLIP, 16'h0019);
    clip_case(16'h9c40, 16'h8000, 16'h8c80, 16'h8000, 1'b1);
    rd_reg(`OGM_OFF_STATUS);
    check({15'h0000, rd[0]}, 16'h0001);
    clip_case(16'h4e20, 16'h8000, 16'h7380, 16'h8000, 1'b1);
    clip_case(16'h8000, 16'h9c40, 16'h8000, 16'h8c80, 1'b1);
    clip_case(16'h8000, 16'h8000, 16'h8000, 16'h8000, 1'b0);
    wr(`OGM_OFF_CLIP, 16'h0000);
    clip_case(16'h9c40, 16'h0000, 16'h8000, 16'h8000, 1'b1);
    wr(`OGM_OFF_CLIP, 16'h00ff);
    clip_case(16'hffff, 16'h0000, 16'hffff, 16'h0000, 1'b0);
    wr(`OGM_OFF_CTRL, 16'h0021);
    wr(`OGM_OFF_CLIP, 16'h0019);
    clip_case(16'h9c40, 16'h4e20, 16'h9c40, 16'h4e20, 1'b0);
    wr(`OGM_OFF_CTRL, 16'h0001);
    wr(`OGM_OFF_CLIP, 16'h00ff);
    $display("clip test done");
  endtask
  task automatic t_range();
    wr(`OGM_OFF_RANGE, 16'h0100);
    range_case(16'h00ff, 16'hff01, 1'b0);
    range_case(16'h0100, 16'h0000, 1'b1);
    range_case(16'h0000, 16'hff00, 1'b1);
    wr(`OGM_OFF_CTRL, 16'h0021);
    range_case(16'h80ff, 16'h7f01, 1'b0);
    range_case(16'h8100, 16'h8000, 1'b1);
    wr(`OGM_OFF_CTRL, 16'h0001);
    wr(`OGM_OFF_RANGE, 16'hffff);
    $display("range test done");
  endtask
  // low nine bits of I are set so that a wider meter would read more
  task automatic t_power();
    wr(`OGM_OFF_PWIN, 16'h0000);
    wr(`OGM_OFF_PTHR, 16'h07ff);
    drive(16'h41ff, 16'hc000);
    repeat (200) @(posedge i_sys_clk);
    #1;
    check({15'h0000, o_power_over_flag}, 16'h0001);
    rd_reg(`OGM_OFF_PAVG);
    check(rd, 16'h0800);
    wr(`OGM_OFF_PTHR, 16'h0800);
    repeat (200) @(posedge i_sys_clk);
    #1;
    check({15'h0000, o_power_over_flag}, 16'h0000);
    wr(`OGM_OFF_PTHR, 16'hffff);
    $display("power test done");
  endtask
  task automatic t_mute();
    wr(`OGM_OFF_CTRL, 16'h0001);
    wr(`OGM_OFF_RATES, 16'h0000);
    wr(`OGM_OFF_WAIT, 16'h0002);
    wr(`OGM_OFF_OFS_A, 16'h0020);
    drive(16'h1000, 16'h0000);
    @(posedge i_sys_clk);
    mute_req <= 1'b1;
    wait_state(ogm_pkg::OGM_WAIT, 300);
    check({15'h0000, (n >= 126 && n <= 136)}, 16'h0001);
    check(o_sample_a, 16'h0020);
    check({15'h0000, o_muted}, 16'h0001);
    n = 0;
    while (o_mute_state === ogm_pkg::OGM_WAIT && n < 100) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    check({15'h0000, (n >= 23 && n <= 25)}, 16'h0001);
    mute_req <= 1'b0;
    wait_state(ogm_pkg::OGM_RUN, 1000);
    drive(16'h1000, 16'h0000);
    check(o_sample_a, 16'h1020);
    wr(`OGM_OFF_OFS_A, 16'h0000);
    $display("mute test done");
  endtask
  task automatic t_alarm();
    wr(`OGM_OFF_CTRL, 16'h0031);
    wr(`OGM_OFF_EVEN, 16'h0001);
    wr(`OGM_OFF_CLIP, 16'h0000);
    drive(16'h9000, 16'h8000);
    wait_state(ogm_pkg::OGM_WAIT, 300);
    drive(16'h8000, 16'h8000);
    repeat (100) @(posedge i_sys_clk);
    #1;
    check({14'h0000, o_mute_state}, {14'h0000, ogm_pkg::OGM_WAIT});
    wr(`OGM_OFF_CTRL, 16'h0071);
    wait_state(ogm_pkg::OGM_RUN, 400);
    wr(`OGM_OFF_EVEN, 16'h0000);
    wr(`OGM_OFF_CTRL, 16'h0001);
    wr(`OGM_OFF_CLIP, 16'h00ff);
    $display("alarm test done");
  endtask
  // pin ignored, then a data mute released long before its wait runs out
  task automatic t_cats();
    wr(`OGM_OFF_CTRL, 16'h0003);
    @(posedge i_sys_clk);
    mute_req <= 1'b1;
    repeat (20) @(posedge i_sys_clk);
    #1;
    check({14'h0000, o_mute_state}, {14'h0000, ogm_pkg::OGM_RUN});
    @(posedge i_sys_clk);
    mute_req <= 1'b0;
    wr(`OGM_OFF_CTRL, 16'h0001);
    wr(`OGM_OFF_WAIT, 16'h0100);
    @(posedge i_sys_clk);
    bad_data <= 1'b1;
    wait_state(ogm_pkg::OGM_WAIT, 300);
    @(posedge i_sys_clk);
    bad_data <= 1'b0;
    n = 0;
    while (o_mute_state === ogm_pkg::OGM_WAIT && n < 100) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    check({15'h0000, (n >= 2 && n <= 4)}, 16'h0001);
    wait_state(ogm_pkg::OGM_RUN, 400);
    wr(`OGM_OFF_WAIT, 16'h0000);
    $display("category test done");
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    t_reset();
    t_offset();
    t_clip();
    t_range();
    t_power();
    t_mute();
    t_alarm();
    t_cats();
    final_report();
  end
endmodule

// File: ogm_pkg.sv
package ogm_pkg;
  // mute controller states
  typedef enum logic [1:0] {OGM_RUN, OGM_MUTE, OGM_WAIT, OGM_DEMUTE} ogm_state_t;
  // mute categories, highest priority first
  typedef enum logic [1:0] {OGM_DIRECT, OGM_ALARM, OGM_DATA, OGM_INCIDENT} ogm_cat_t;
endpackage

// File: ogm_stream_source.sv
module ogm_stream_source (
  // clock
  input wire logic i_sys_clk,
  // commands from the bench
  input wire logic [15:0] i_next_i,
  input wire logic [15:0] i_next_q,
  input wire logic i_mute_req,
  input wire logic i_data_bad,
  // stream and pin toward the guard
  output logic [15:0] o_sample_a = 16'h0000,
  output logic [15:0] o_sample_b = 16'h0000,
  output logic o_data_invalid = 1'b0,
  output logic o_output_enable_pin_n = 1'b1
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // upstream datapath
  // one pair per clock, never stalls; data flagged bad only on request
  always @(posedge i_sys_clk) begin
    o_sample_a <= i_next_i;
    o_sample_b <= i_next_q;
    o_data_invalid <= i_data_bad;
  end
  // pin held high
  // low only while a shutdown is wanted, so normal output keeps flowing
  always @(posedge i_sys_clk) begin
    o_output_enable_pin_n <= ~i_mute_req;
  end
endmodule
